/* File: src/dbg_defines.svh */
// What this block does
// - block-next address is previous address plus previous access size in bytes.
// - misaligned 32-bit access clears address bits 1:0; next continues at next field.
// - realigned 16-bit access increments the original address for the next access.
// - 16-bit access straddling a 4-byte boundary is pulled back inside its field.
// - repeat-read bases on the unadjusted address of the last memory read.
// - repeat-read of other size keeps base, aligns 32/16-bit inside the field.
// - pin selects operating mode during reset, serial link only afterwards.
// - serial timing runs from a target clock chosen by a clock-select bit.
// - each bit lasts 16 target clocks; values go most significant bit first.
// - 512 target clocks between host edges in a command discard the command.
// - pin is driven only low, except brief high speedup pulses.
// - host edge is synchronised with one clock uncertainty; delays timed from detection.
// - received bit is sampled ten target clocks after the detected edge.
// - returned one gets a speedup pulse seven target clocks after bit start.
// - returned zero holds low 13 target clocks, then a speedup pulse.
// - failed read returns 0xEE bytes; illegal access voids fill and repeat-read.
// - unimplemented command during a block sequence ends that sequence.
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH
`define DBG_BIT_LAST 4'hF
`define DBG_RX_SAMPLE 4'hA
`define DBG_TX1_SPEEDUP 4'h7
`define DBG_TX0_SPEEDUP 4'hD
`define DBG_TIMEOUT_TICKS 10'h200
`define DBG_ERR_BYTE 8'hEE
`define DBG_BYTES_8 3'h1
`define DBG_BYTES_16 3'h2
`define DBG_BYTES_32 3'h4
`define DBG_LANE_FIRST 2'h0
`define DBG_LANE_HALF2 2'h2
`define DBG_LANE_LAST 2'h3
`endif

/* File: src/dbg_pkg.sv */
package dbg_pkg;
  typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32} dbg_size_t;
  typedef enum logic [2:0] {
    CMD_READ_MEM, CMD_WRITE_MEM, CMD_DUMP, CMD_FILL, CMD_READ_SAME, CMD_UNIMPL, CMD_OTHER
  } dbg_cmd_t;
  typedef enum logic {ST_IDLE, ST_BIT} dbg_state_t;
endpackage

/* File: src/dbg_addr_seq.sv */
`timescale 1ns/1ps
`include "dbg_defines.svh"
module dbg_addr_seq import dbg_pkg::*; #(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command from the decoder
  input wire logic cmd_valid,
  input wire dbg_cmd_t cmd,
  input wire dbg_size_t cmd_size,
  input wire logic [ADDR_W-1:0] cmd_addr,
  // memory access side
  output logic acc_go,
  output logic [ADDR_W-1:0] acc_addr,
  output dbg_size_t acc_size,
  output logic acc_reject,
  input wire logic acc_done,
  input wire logic acc_illegal,
  input wire logic [31:0] acc_rdata,
  output logic [31:0] rd_data,
  output logic rd_valid
);
  logic [ADDR_W-1:0] next_ff, nxt_next, base_ff, nxt_base, addr_ff, nxt_addr;
  logic dump_ok_ff, nxt_dump_ok, same_ok_ff, nxt_same_ok, go_ff, nxt_go, rej_ff, nxt_rej;
  logic rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  dbg_size_t size_ff, nxt_size;
  logic [ADDR_W-1:0] req;

  generate
    if (ADDR_W < 4) begin : g_chk
      $error("dbg_addr_seq: ADDR_W too small");
    end
  endgenerate

  function automatic logic [ADDR_W-1:0] align_addr(input logic [ADDR_W-1:0] a,
                                                   input dbg_size_t s);
    logic [ADDR_W-1:0] r;
    r = a;
    if (s == SZ_32) begin
      r[1:0] = `DBG_LANE_FIRST;
    end else if (s == SZ_16 && a[1:0] == `DBG_LANE_LAST) begin
      r[1:0] = `DBG_LANE_HALF2;
    end
    return r;
  endfunction

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input dbg_size_t s);
    logic [ADDR_W-1:0] r;
    r = a;
    case (s)
      SZ_32: r = align_addr(a, s) + {{(ADDR_W-3){1'b0}}, `DBG_BYTES_32};
      SZ_16: r = a + {{(ADDR_W-3){1'b0}}, `DBG_BYTES_16};
      default: r = a + {{(ADDR_W-3){1'b0}}, `DBG_BYTES_8};
    endcase
    return r;
  endfunction

  always_comb begin
    req = cmd_addr;
    nxt_next = next_ff;
    nxt_base = base_ff;
    nxt_addr = addr_ff;
    nxt_size = size_ff;
    nxt_dump_ok = dump_ok_ff;
    nxt_same_ok = same_ok_ff;
    nxt_go = 1'b0;
    nxt_rej = 1'b0;
    nxt_rv = 1'b0;
    nxt_rd = rd_ff;
    // illegal voids fill and repeat-read; dump continues
    if (acc_done && acc_illegal) begin
      nxt_same_ok = 1'b0;
    end
    if (acc_done) begin
      nxt_rv = 1'b1;
      nxt_rd = acc_illegal ? {4{`DBG_ERR_BYTE}} : acc_rdata;
    end
    if (cmd_valid) begin
      case (cmd)
        CMD_READ_MEM, CMD_WRITE_MEM: begin
          req = cmd_addr;
          nxt_go = 1'b1;
          nxt_dump_ok = 1'b1;
          nxt_same_ok = 1'b1;
          // base is the unadjusted read address
          if (cmd == CMD_READ_MEM) begin
            nxt_base = cmd_addr;
          end
        end
        CMD_DUMP, CMD_FILL: begin
          req = next_ff;
          nxt_go = (cmd == CMD_DUMP) ? dump_ok_ff : same_ok_ff;
        end
        CMD_READ_SAME: begin
          req = base_ff;
          nxt_go = same_ok_ff;
        end
        CMD_UNIMPL: begin
          nxt_dump_ok = 1'b0;
          nxt_same_ok = 1'b0;
        end
        default: begin
          nxt_go = 1'b0;
        end
      endcase
      if (cmd == CMD_DUMP || cmd == CMD_FILL || cmd == CMD_READ_SAME) begin
        nxt_rej = ~nxt_go;
        if (!nxt_go && cmd != CMD_FILL) begin
          nxt_rv = 1'b1;
          nxt_rd = {4{`DBG_ERR_BYTE}};
        end
      end
      if (nxt_go) begin
        // align so no access leaves its field
        nxt_addr = align_addr(req, cmd_size);
        nxt_size = cmd_size;
        // next address from original address plus size; 32-bit steps from the aligned address
        if (cmd != CMD_READ_SAME) begin
          nxt_next = step_addr(req, cmd_size);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      next_ff <= '0;
      base_ff <= '0;
      addr_ff <= '0;
      size_ff <= SZ_8;
      dump_ok_ff <= 1'b0;
      same_ok_ff <= 1'b0;
      go_ff <= 1'b0;
      rej_ff <= 1'b0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h00000000;
    end else begin
      next_ff <= nxt_next;
      base_ff <= nxt_base;
      addr_ff <= nxt_addr;
      size_ff <= nxt_size;
      dump_ok_ff <= nxt_dump_ok;
      same_ok_ff <= nxt_same_ok;
      go_ff <= nxt_go;
      rej_ff <= nxt_rej;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
    end
  end

  assign acc_go = go_ff;
  assign acc_addr = addr_ff;
  assign acc_size = size_ff;
  assign acc_reject = rej_ff;
  assign rd_data = rd_ff;
  assign rd_valid = rv_ff;

  long_align_a: assert property (@(posedge clk) disable iff (!nrst)
    go_ff && size_ff == SZ_32 |-> addr_ff[1:0] == `DBG_LANE_FIRST)
    else $error("32-bit access not aligned");
  word_inside_a: assert property (@(posedge clk) disable iff (!nrst)
    go_ff && size_ff == SZ_16 |-> addr_ff[1:0] != `DBG_LANE_LAST)
    else $error("16-bit access crosses field");
  err_bytes_a: assert property (@(posedge clk) disable iff (!nrst)
    acc_done && acc_illegal |=> rv_ff && rd_ff == {4{`DBG_ERR_BYTE}})
    else $error("failed read did not return error bytes");
  unimpl_end_a: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd == CMD_UNIMPL |=> !dump_ok_ff && !same_ok_ff)
    else $error("sequence survived unimplemented command");
  same_base_a: assert property (@(posedge clk) disable iff (!nrst)
    cmd_valid && cmd == CMD_READ_SAME && same_ok_ff && cmd_size == SZ_8
    |=> go_ff && addr_ff == $past(base_ff))
    else $error("repeat-read used wrong base");
endmodule

/* File: src/dbg_link.sv */
`timescale 1ns/1ps
`include "dbg_defines.svh"
module dbg_link import dbg_pkg::*; #(
  parameter int BYTE_BITS = 8,
  parameter int ALT_DIV = 2,
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // debug pin
  input wire logic DEBUG_PIN_IN,
  output logic DEBUG_PIN_OUT,
  output logic DEBUG_PIN_OE,
  // mode and clocking
  input wire logic SERIAL_CLOCK_SELECT,
  output logic MODE_SPECIAL,
  // byte stream
  input wire logic CMD_ACTIVE,
  output logic [BYTE_BITS-1:0] RX_BYTE,
  output logic RX_BYTE_VALID,
  input wire logic [BYTE_BITS-1:0] TX_BYTE,
  input wire logic TX_LOAD,
  output logic TX_BUSY,
  output logic TIMEOUT,
  // memory sequencing
  input wire logic SEQ_CMD_VALID,
  input wire dbg_cmd_t SEQ_CMD,
  input wire dbg_size_t SEQ_SIZE,
  input wire logic [ADDR_W-1:0] SEQ_ADDR,
  output logic ACC_GO,
  output logic [ADDR_W-1:0] ACC_ADDR,
  output dbg_size_t ACC_SIZE,
  output logic ACC_REJECT,
  input wire logic ACC_DONE,
  input wire logic ACC_ILLEGAL,
  input wire logic [31:0] ACC_RDATA,
  output logic [31:0] RD_DATA,
  output logic RD_DATA_VALID
);
  localparam int CW = $clog2(BYTE_BITS + 1);

  generate
    if (BYTE_BITS < 2 || ALT_DIV < 1 || ALT_DIV > 256) begin : g_chk
      $error("dbg_link: unsupported parameter value");
    end
  endgenerate

  logic [7:0] div_ff, nxt_div, div_lim;
  logic tick;
  dbg_state_t st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [9:0] gap_ff, nxt_gap;
  logic pin_prev_ff, nxt_pin_prev, fall;
  logic strap_done_ff, nxt_strap_done, mode_ff, nxt_mode;
  logic bit_tx_ff, nxt_bit_tx, cur_bit_ff, nxt_cur_bit;
  logic [BYTE_BITS-1:0] tx_sh_ff, nxt_tx_sh, rx_sh_ff, nxt_rx_sh, rxb_ff, nxt_rxb;
  logic [CW-1:0] tx_left_ff, nxt_tx_left, rx_cnt_ff, nxt_rx_cnt;
  logic rxv_ff, nxt_rxv, to_ff, nxt_to, busy_ff, nxt_busy;
  logic oe_ff, nxt_oe, out_ff, nxt_out;

  // target clock enable chosen by the select bit
  assign div_lim = SERIAL_CLOCK_SELECT ? 8'h00 : 8'(ALT_DIV - 1);
  assign tick = (div_ff == 8'h00);
  // edge seen at a target clock tick, up to one tick late
  assign fall = strap_done_ff & tick & pin_prev_ff & ~DEBUG_PIN_IN;

  always_comb begin
    nxt_div = (div_ff >= div_lim) ? 8'h00 : div_ff + 8'h01;
    nxt_pin_prev = tick ? DEBUG_PIN_IN : pin_prev_ff;
    // pin read as mode strap only at reset release
    nxt_strap_done = 1'b1;
    nxt_mode = strap_done_ff ? mode_ff : ~DEBUG_PIN_IN;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_gap = gap_ff;
    nxt_bit_tx = bit_tx_ff;
    nxt_cur_bit = cur_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_left = tx_left_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rxb = rxb_ff;
    nxt_rxv = 1'b0;
    nxt_to = 1'b0;
    if (TX_LOAD && tx_left_ff == '0) begin
      nxt_tx_sh = TX_BYTE;
      nxt_tx_left = CW'(BYTE_BITS);
    end
    case (st_ff)
      ST_IDLE: begin
        // every bit begins at a host falling edge
        if (fall) begin
          nxt_st = ST_BIT;
          nxt_cnt = 4'h0;
          nxt_bit_tx = (tx_left_ff != '0);
          nxt_cur_bit = tx_sh_ff[BYTE_BITS-1];
          if (tx_left_ff != '0) begin
            nxt_tx_sh = {tx_sh_ff[BYTE_BITS-2:0], 1'b0};
            nxt_tx_left = tx_left_ff - CW'(1);
          end
        end
      end
      ST_BIT: begin
        if (tick) begin
          // sample ten ticks after the detected edge
          if (!bit_tx_ff && cnt_ff == `DBG_RX_SAMPLE) begin
            nxt_rx_sh = {rx_sh_ff[BYTE_BITS-2:0], DEBUG_PIN_IN};
            if (rx_cnt_ff == CW'(BYTE_BITS - 1)) begin
              nxt_rx_cnt = '0;
              nxt_rxv = 1'b1;
              nxt_rxb = {rx_sh_ff[BYTE_BITS-2:0], DEBUG_PIN_IN};
            end else begin
              nxt_rx_cnt = rx_cnt_ff + CW'(1);
            end
          end
          if (cnt_ff == `DBG_BIT_LAST) begin
            nxt_st = ST_IDLE;
          end else begin
            nxt_cnt = cnt_ff + 4'h1;
          end
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    // gap of 512 ticks discards the command
    if (fall || !CMD_ACTIVE) begin
      nxt_gap = 10'h000;
    end else if (tick) begin
      if (gap_ff == `DBG_TIMEOUT_TICKS - 10'h001) begin
        nxt_gap = 10'h000;
        nxt_to = 1'b1;
        nxt_rx_cnt = '0;
        nxt_tx_left = '0;
      end else begin
        nxt_gap = gap_ff + 10'h001;
      end
    end
    nxt_busy = (nxt_tx_left != '0);
    // only low drive plus single-tick speedup pulses
    nxt_oe = 1'b0;
    nxt_out = 1'b0;
    if (nxt_st == ST_BIT && nxt_bit_tx) begin
      if (nxt_cur_bit) begin
        // speedup for a one at tick seven
        nxt_oe = (nxt_cnt == `DBG_TX1_SPEEDUP);
        nxt_out = nxt_oe;
      end else begin
        // zero held low until tick thirteen, then speedup
        nxt_oe = (nxt_cnt <= `DBG_TX0_SPEEDUP);
        nxt_out = (nxt_cnt == `DBG_TX0_SPEEDUP);
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      div_ff <= 8'h00;
      pin_prev_ff <= 1'b1;
      strap_done_ff <= 1'b0;
      mode_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      pin_prev_ff <= nxt_pin_prev;
      strap_done_ff <= nxt_strap_done;
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      gap_ff <= 10'h000;
      bit_tx_ff <= 1'b0;
      cur_bit_ff <= 1'b0;
      tx_sh_ff <= '0;
      tx_left_ff <= '0;
      rx_sh_ff <= '0;
      rx_cnt_ff <= '0;
      rxb_ff <= '0;
      rxv_ff <= 1'b0;
      to_ff <= 1'b0;
      busy_ff <= 1'b0;
      oe_ff <= 1'b0;
      out_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      gap_ff <= nxt_gap;
      bit_tx_ff <= nxt_bit_tx;
      cur_bit_ff <= nxt_cur_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_left_ff <= nxt_tx_left;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rxb_ff <= nxt_rxb;
      rxv_ff <= nxt_rxv;
      to_ff <= nxt_to;
      busy_ff <= nxt_busy;
      oe_ff <= nxt_oe;
      out_ff <= nxt_out;
    end
  end

  assign DEBUG_PIN_OUT = out_ff;
  assign DEBUG_PIN_OE = oe_ff;
  assign MODE_SPECIAL = mode_ff;
  assign RX_BYTE = rxb_ff;
  assign RX_BYTE_VALID = rxv_ff;
  assign TX_BUSY = busy_ff;
  assign TIMEOUT = to_ff;

  dbg_addr_seq #(.ADDR_W(ADDR_W)) u_seq (
    .clk(CORE_CLK),
    .nrst(NRST),
    .cmd_valid(SEQ_CMD_VALID),
    .cmd(SEQ_CMD),
    .cmd_size(SEQ_SIZE),
    .cmd_addr(SEQ_ADDR),
    .acc_go(ACC_GO),
    .acc_addr(ACC_ADDR),
    .acc_size(ACC_SIZE),
    .acc_reject(ACC_REJECT),
    .acc_done(ACC_DONE),
    .acc_illegal(ACC_ILLEGAL),
    .acc_rdata(ACC_RDATA),
    .rd_data(RD_DATA),
    .rd_valid(RD_DATA_VALID)
  );

  edge_start_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    st_ff == ST_IDLE && fall |=> st_ff == ST_BIT && cnt_ff == 4'h0)
    else $error("falling edge did not start a bit");
  bit_end_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    st_ff == ST_BIT && tick && cnt_ff == `DBG_BIT_LAST |=> st_ff == ST_IDLE)
    else $error("bit period not sixteen ticks");
  zero_low_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    st_ff == ST_BIT && bit_tx_ff && !cur_bit_ff && cnt_ff < `DBG_TX0_SPEEDUP
    |-> DEBUG_PIN_OE && !DEBUG_PIN_OUT)
    else $error("zero bit not held low");
  one_speedup_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    st_ff == ST_BIT && bit_tx_ff && cur_bit_ff
    |-> DEBUG_PIN_OE == (cnt_ff == `DBG_TX1_SPEEDUP))
    else $error("one bit speedup misplaced");
  high_only_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    DEBUG_PIN_OE && DEBUG_PIN_OUT |-> st_ff == ST_BIT && bit_tx_ff
    && (cnt_ff == `DBG_TX1_SPEEDUP || cnt_ff == `DBG_TX0_SPEEDUP))
    else $error("pin driven high outside speedup");
  gap_timeout_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CMD_ACTIVE && tick && !fall && gap_ff == `DBG_TIMEOUT_TICKS - 10'h001
    |=> TIMEOUT && !TX_BUSY)
    else $error("timeout not raised after 512 ticks");
  rx_byte_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    RX_BYTE_VALID |-> $past(st_ff) == ST_BIT && $past(cnt_ff) == `DBG_RX_SAMPLE
    && $past(tick))
    else $error("byte completed away from sample point");
  strap_hold_a: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    strap_done_ff ##1 strap_done_ff |-> $stable(MODE_SPECIAL))
    else $error("mode changed after reset");
endmodule

/* File: testbench/dbg_host.sv */
`timescale 1ns/1ps
module dbg_host (
  // clock and resolved pin
  input wire logic clk,
  input wire logic pin,
  // device drive, seen to time its speedup pulse
  input wire logic dev_oe,
  input wire logic dev_out,
  // host drive
  output logic drive_low,
  output logic drive_high
);
  initial begin
    drive_low = 1'b0;
    drive_high = 1'b0;
  end

  task automatic send_bit(input logic b, input int div);
    int n;
    n = b ? 4 * div : 13 * div;
    @(negedge clk);
    drive_low = 1'b1;
    repeat (n) @(negedge clk);
    drive_low = 1'b0;
    drive_high = 1'b1;
    @(negedge clk);
    drive_high = 1'b0;
    repeat (18 * div - n - 1) @(negedge clk);
  endtask

  task automatic send_byte(input logic [7:0] v, input int div);
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i], div);
    end
  endtask

  task automatic recv_bit(output logic b, output int spd, input int div);
    spd = -1;
    b = 1'b0;
    @(negedge clk);
    drive_low = 1'b1;
    for (int k = 0; k < 18 * div; k++) begin
      @(posedge clk);
      #1;
      if (spd < 0 && dev_oe === 1'b1 && dev_out === 1'b1) begin
        spd = k;
      end
      if (k == 10 * div - 1) begin
        b = pin;
      end
      if (k == 3 * div - 1) begin
        @(negedge clk);
        drive_low = 1'b0;
      end
    end
  endtask
endmodule

/* File: testbench/dbg_link_test.sv */
`timescale 1ns/1ps
module dbg_link_test import dbg_pkg::*; ;
  typedef struct {
    dbg_cmd_t cmd;
    dbg_size_t size;
    logic [23:0] addr;
    logic ill;
    logic [1:0] res;
    logic [23:0] ea;
  } dbg_row_t;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_sel = 1'b1;
  logic cmd_active = 1'b0;
  logic tx_load = 1'b0;
  logic seq_valid = 1'b0;
  logic mem_ill = 1'b0;
  logic acc_done = 1'b0;
  logic acc_illegal = 1'b0;
  logic [31:0] acc_rdata = 32'h0;
  logic [7:0] tx_byte = 8'h0;
  dbg_cmd_t seq_cmd = CMD_OTHER;
  dbg_size_t seq_size = SZ_8;
  logic [23:0] seq_addr = 24'h0;
  logic pin_in, pin_out, pin_oe, mode_special, rx_valid, tx_busy, timeout;
  logic acc_go, acc_reject, rd_valid, host_low, host_high, rd;
  logic [7:0] rx_byte, rx_last;
  logic [23:0] acc_addr;
  dbg_size_t acc_size;
  logic [31:0] rd_data;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int rx_n = 0;
  int w, n;

  // ordinary sequencer cases: command, size, address, illegal, {go,reject}, access address
  dbg_row_t rows [32] = '{
    '{CMD_DUMP, SZ_8, 24'h000000, 1'b0, 2'h1, 24'h000000},
    '{CMD_READ_MEM, SZ_32, 24'h004003, 1'b0, 2'h2, 24'h004000},
    '{CMD_DUMP, SZ_32, 24'h000000, 1'b0, 2'h2, 24'h004004},
    '{CMD_DUMP, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h004008},
    '{CMD_DUMP, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h00400A},
    '{CMD_DUMP, SZ_8, 24'h000000, 1'b0, 2'h2, 24'h00400C},
    '{CMD_DUMP, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h00400D},
    '{CMD_DUMP, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h00400E},
    '{CMD_DUMP, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h004011},
    '{CMD_READ_MEM, SZ_32, 24'h004003, 1'b0, 2'h2, 24'h004000},
    '{CMD_READ_SAME, SZ_32, 24'h000000, 1'b0, 2'h2, 24'h004000},
    '{CMD_READ_SAME, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h004002},
    '{CMD_READ_SAME, SZ_8, 24'h000000, 1'b0, 2'h2, 24'h004003},
    '{CMD_READ_MEM, SZ_8, 24'h004002, 1'b0, 2'h2, 24'h004002},
    '{CMD_READ_SAME, SZ_16, 24'h000000, 1'b0, 2'h2, 24'h004002},
    '{CMD_READ_SAME, SZ_32, 24'h000000, 1'b0, 2'h2, 24'h004000},
    '{CMD_READ_MEM, SZ_16, 24'h004001, 1'b0, 2'h2, 24'h004001},
    '{CMD_READ_SAME, SZ_8, 24'h000000, 1'b0, 2'h2, 24'h004001},
    '{CMD_READ_SAME, SZ_32, 24'h000000, 1'b0, 2'h2, 24'h004000},
    '{CMD_READ_MEM, SZ_16, 24'h004003, 1'b0, 2'h2, 24'h004002},
    '{CMD_READ_SAME, SZ_8, 24'h000000, 1'b0, 2'h2, 24'h004003},
    '{CMD_UNIMPL, SZ_8, 24'h000000, 1'b0, 2'h0, 24'h000000},
    '{CMD_DUMP, SZ_8, 24'h000000, 1'b0, 2'h1, 24'h000000},
    '{CMD_READ_SAME, SZ_8, 24'h000000, 1'b0, 2'h1, 24'h000000},
    '{CMD_WRITE_MEM, SZ_32, 24'h004042, 1'b0, 2'h2, 24'h004040},
    '{CMD_FILL, SZ_32, 24'h000000, 1'b0, 2'h2, 24'h004044},
    '{CMD_FILL, SZ_8, 24'h000000, 1'b0, 2'h2, 24'h004048},
    '{CMD_READ_MEM, SZ_8, 24'h004030, 1'b1, 2'h2, 24'h004030},
    '{CMD_FILL, SZ_8, 24'h000000, 1'b0, 2'h1, 24'h000000},
    '{CMD_READ_SAME, SZ_8, 24'h000000, 1'b0, 2'h1, 24'h000000},
    '{CMD_DUMP, SZ_8, 24'h000000, 1'b0, 2'h2, 24'h004031},
    '{CMD_OTHER, SZ_8, 24'h000000, 1'b0, 2'h0, 24'h000000}
  };

  // open-drain pin with pull-up: any low driver wins unless the host drives a speedup pulse
  assign pin_in = host_high ? 1'b1 : (host_low || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;

  always #5 core_clk = ~core_clk;

  dbg_link #(.BYTE_BITS(8), .ALT_DIV(2), .ADDR_W(24)) dut (
    .CORE_CLK(core_clk), .NRST(nrst), .DEBUG_PIN_IN(pin_in), .DEBUG_PIN_OUT(pin_out),
    .DEBUG_PIN_OE(pin_oe), .SERIAL_CLOCK_SELECT(clk_sel), .MODE_SPECIAL(mode_special),
    .CMD_ACTIVE(cmd_active), .RX_BYTE(rx_byte), .RX_BYTE_VALID(rx_valid), .TX_BYTE(tx_byte),
    .TX_LOAD(tx_load), .TX_BUSY(tx_busy), .TIMEOUT(timeout), .SEQ_CMD_VALID(seq_valid),
    .SEQ_CMD(seq_cmd), .SEQ_SIZE(seq_size), .SEQ_ADDR(seq_addr), .ACC_GO(acc_go),
    .ACC_ADDR(acc_addr), .ACC_SIZE(acc_size), .ACC_REJECT(acc_reject), .ACC_DONE(acc_done),
    .ACC_ILLEGAL(acc_illegal), .ACC_RDATA(acc_rdata), .RD_DATA(rd_data),
    .RD_DATA_VALID(rd_valid)
  );

  dbg_host host (
    .clk(core_clk), .pin(pin_in), .dev_oe(pin_oe), .dev_out(pin_out),
    .drive_low(host_low), .drive_high(host_high)
  );

  // memory answers every access next cycle; data churns when not valid
  always @(negedge core_clk) begin
    acc_done = acc_go;
    acc_illegal = acc_go && mem_ill;
    acc_rdata = acc_go ? {8'h5A, acc_addr} : ~acc_rdata;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (rx_valid === 1'b1) begin
      rx_n++;
      rx_last = rx_byte;
    end
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic low);
    nrst = 1'b0;
    host.drive_low = low;
    repeat (5) @(negedge core_clk);
    check({26'h0, mode_special, acc_go, tx_busy, timeout, rx_valid, pin_oe}, 32'h0);
    nrst = 1'b1;
    @(negedge core_clk);
    check({31'h0, mode_special}, {31'h0, low});
    host.drive_low = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rx_test(input logic [7:0] v, input int div);
    n = rx_n;
    host.send_byte(v, div);
    check(rx_n - n, 32'h1);
    check({24'h0, rx_last}, {24'h0, v});
  endtask

  task automatic tx_test(input logic [7:0] v, input int div);
    logic b;
    int spd;
    tx_byte = v;
    tx_load = 1'b1;
    @(negedge core_clk);
    tx_load = 1'b0;
    check({31'h0, tx_busy}, 32'h1);
    for (int i = 7; i >= 0; i--) begin
      host.recv_bit(b, spd, div);
      check({31'h0, b}, {31'h0, v[i]});
      if (div == 1) check(spd, v[i] ? 32'h7 : 32'hD);
    end
    check({31'h0, tx_busy}, 32'h0);
  endtask

  initial begin
    do_reset(1'b0);
    foreach (rows[i]) begin
      mem_ill = rows[i].ill;
      seq_cmd = rows[i].cmd;
      seq_size = rows[i].size;
      seq_addr = rows[i].addr;
      seq_valid = 1'b1;
      @(negedge core_clk);
      seq_valid = 1'b0;
      check({30'h0, acc_go, acc_reject}, {30'h0, rows[i].res});
      if (rows[i].res == 2'h2) begin
        check({6'h0, acc_size, acc_addr}, {6'h0, rows[i].size, rows[i].ea});
      end
      rd = rows[i].cmd inside {CMD_READ_MEM, CMD_DUMP, CMD_READ_SAME};
      // a refused read answers with error bytes in the same cycle as the reject
      if (rd && rows[i].res == 2'h1) begin
        check({31'h0, rd_valid}, 32'h1);
      end
      @(negedge core_clk);
      if (rd && rows[i].res == 2'h2) begin
        check({31'h0, rd_valid}, 32'h1);
      end
      if (rd && rows[i].res != 2'h0) begin
        check(rd_data, (rows[i].ill || rows[i].res == 2'h1) ? 32'hEEEEEEEE :
          {8'h5A, rows[i].ea});
      end
    end
    rx_test(8'hA5, 1);
    tx_test(8'h6C, 1);
    // a stalled host mid-byte must lose the partial byte
    cmd_active = 1'b1;
    repeat (3) host.send_bit(1'b1, 1);
    w = 0;
    while (timeout !== 1'b1 && w < 600) begin
      @(negedge core_clk);
      w++;
    end
    check({31'h0, w > 490 && w < 500}, 32'h1);
    rx_test(8'h81, 1);
    cmd_active = 1'b0;
    clk_sel = 1'b0;
    rx_test(8'h3C, 2);
    tx_test(8'hC3, 2);
    clk_sel = 1'b1;
    do_reset(1'b1);
    test_done();
  end
endmodule
